// ==== inc/sleep_wakeup_pkg.sv ====
package sleep_wakeup_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFS_COARSE_TRIM = 8'he8;
  localparam logic [7:0] OFS_LEGACY_DUTY = 8'heb;
  localparam logic [7:0] OFS_BUZZ_I2C = 8'hec;
  localparam logic [7:0] OFS_WAKE_TAP = 8'hed;
  localparam logic [7:0] OFS_SEQ_STATUS = 8'hee;
  localparam logic [7:0] OFS_FINE_TRIM = 8'hfa;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int SLOW_OSC_OFF_BIT = 0;
  localparam int I2C_SLEEP_BIT = 1;
  localparam int ALT_BUZZ_LSB = 2;
  localparam int FIRST_TAP_LSB = 0;
  localparam int SECOND_TAP_LSB = 2;
  localparam int THIRD_TAP_LSB = 4;
  localparam int DOUBLE_BIT = 6;
  localparam int LEGACY_DUTY_LSB = 6;
  localparam int FINE_W = 3;
  localparam int BUZZ_CFG_W = 4;
  localparam int TAP_CFG_W = 7;
  localparam int STATUS_BUZZ_BIT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [BUZZ_CFG_W-1:0] RST_BUZZ_I2C = 4'h0;
  localparam logic [TAP_CFG_W-1:0] RST_WAKE_TAP = 7'h7f;
  localparam logic [1:0] RST_LEGACY_DUTY = 2'h0;
  localparam logic [7:0] RST_COARSE_TRIM = 8'h00;
  localparam logic [FINE_W-1:0] RST_FINE_TRIM = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int US_PER_S = 1_000_000;
  localparam int US_CYCLES = (CLK_HZ + US_PER_S - 1) / US_PER_S;
  localparam int DELAY_W = 6;

  // phase delays in microseconds, indexed by tap code
  localparam logic [DELAY_W-1:0] FIRST_US [4] = '{6'h0a, 6'h0e, 6'h14, 6'h1e};
  localparam logic [DELAY_W-1:0] SECOND_US [4] = '{6'h03, 6'h04, 6'h05, 6'h0a};
  localparam logic [DELAY_W-1:0] THIRD_US [4] = '{6'h01, 6'h02, 6'h05, 6'h0a};

  ////////////////////////////////////////////////////////////////////////////
  // buzz selection: slow periods per monitor on-time
  localparam logic [1:0] ALT_COMPAT = 2'h0;
  localparam logic [1:0] ALT_1_32768 = 2'h1;
  localparam logic [1:0] ALT_1_8192 = 2'h2;
  localparam logic [15:0] RATIO_ALT_32768 = 16'h8000;
  localparam logic [15:0] RATIO_ALT_8192 = 16'h2000;
  localparam logic [15:0] LEGACY_RATIO [4] = '{16'h0100, 16'h0400, 16'h0040, 16'h0010};

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FIRST = 4'b0010,
    ST_SECOND = 4'b0100,
    ST_THIRD = 4'b1000
  } seq_state_t;

endpackage

// ==== src/wake_phase_timer.sv ====
`timescale 1ns/10ps
module wake_phase_timer
  import sleep_wakeup_pkg::*;
#(
  parameter int unsigned US_CYC = US_CYCLES,
  parameter int unsigned DLY_W = DELAY_W
) (
  input wire logic sys_clk, // 40 MHz clock
  input wire logic resetn, // async reset, active low
  input wire logic start, // load delay and run
  input wire logic [DLY_W-1:0] delay_us, // delay in microseconds
  output logic expired, // last cycle of the delay
  output logic busy // delay running
);

  localparam int DIV_W = (US_CYC > 1) ? $clog2(US_CYC) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(US_CYC - 1);

  generate
    if (US_CYC < 1 || DLY_W < 1) begin : g_bad
      $error("wake_phase_timer: bad parameters");
    end
  endgenerate

  logic [DIV_W-1:0] div_q;
  logic [DLY_W-1:0] us_q;
  logic busy_q;

  wire us_tick = busy_q && (div_q == '0);
  // zero delay treated as one microsecond so the sequence cannot stall
  assign expired = us_tick && (us_q <= DLY_W'(1));
  assign busy = busy_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= '0;
      us_q <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      div_q <= DIV_LAST;
      us_q <= delay_us;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      div_q <= us_tick ? DIV_LAST : div_q - DIV_W'(1);
      if (us_tick) begin
        us_q <= us_q - DLY_W'(1);
      end
      if (expired) begin
        busy_q <= 1'b0;
      end
    end
  end

endmodule

// ==== src/sleep_wakeup_config.sv ====
// Behaviour
// - alternate buzz code 00 takes the buzz ratio from the legacy sleep duty field.
// - alternate buzz code 01 gives a 1/32768 duty, 10 gives 1/8192, 11 is reserved.
// - the i2c sleep bit powers the standby regulator while asleep.
// - the slow-oscillator off bit stops the low-speed oscillator for the whole sleep.
// - the double bit doubles all three wakeup phase delays.
// - third phase tap codes 00..11 give 1, 2, 5 and 10 microseconds.
// - the third phase runs only in a wakeup, never in a buzz sequence.
// - second phase tap codes 00..11 give 3, 4, 5 and 10 microseconds.
// - first phase tap codes 00..11 give 10, 14, 20 and 30 microseconds.
// - the three fine trim bits join below the eight coarse bits into the oscillator trim word.
// - fine trim is normally written by the locking function; software should leave it and the taps.
// - legacy duty codes 00..11 give on-time ratios of 1/256, 1/1024, 1/64 and 1/16 slow periods.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
module sleep_wakeup_config
  import sleep_wakeup_pkg::*;
#(
  parameter int unsigned US_CYC = US_CYCLES
) (
  input wire logic sys_clk, // 40 MHz clock
  input wire logic resetn, // async reset, active low
  input wire logic [ADDR_W-1:0] reg_addr, // register address
  input wire logic [DATA_W-1:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [DATA_W-1:0] reg_rdata, // read data, cycle after strobe
  input wire logic sleep_active, // device is in sleep state
  input wire logic wake_start, // pulse: begin wakeup sequence
  input wire logic buzz_start, // pulse: begin buzz sequence
  input wire logic lock_trim_wr, // pulse: locking function update
  input wire logic [FINE_W-1:0] lock_trim_val, // new fine trim value
  output logic i2c_standby_en, // standby regulator enable
  output logic slow_osc_run, // low-speed oscillator enable
  output logic [15:0] buzz_on_ratio, // slow periods per monitor on-time
  output logic [10:0] osc_trim_word, // main oscillator trim word
  output logic [2:0] wake_phase, // one-hot first/second/third phase
  output logic seq_busy, // sequence running
  output logic seq_done // pulse: sequence finished
);

  generate
    if (US_CYC < 1) begin : g_bad
      $error("sleep_wakeup_config: US_CYC must be at least 1");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // phase delay decode for the sequencer; the checks below compare against fixed values
  function automatic logic [DELAY_W-1:0] phase_delay(input logic [1:0] ph,
                                                     input logic [TAP_CFG_W-1:0] cfg);
    logic [DELAY_W-1:0] base;
    base = '0;
    unique case (ph)
      2'h0: base = FIRST_US[cfg[FIRST_TAP_LSB +: 2]];
      2'h1: base = SECOND_US[cfg[SECOND_TAP_LSB +: 2]];
      default: base = THIRD_US[cfg[THIRD_TAP_LSB +: 2]];
    endcase
    return cfg[DOUBLE_BIT] ? {base[DELAY_W-2:0], 1'b0} : base;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [BUZZ_CFG_W-1:0] buzz_i2c_q;
  logic [TAP_CFG_W-1:0] wake_tap_q;
  logic [1:0] legacy_duty_q;
  logic [7:0] coarse_trim_q;
  logic [FINE_W-1:0] fine_trim_q;
  logic [DATA_W-1:0] rdata_q;

  wire hit_buzz = reg_addr == OFS_BUZZ_I2C;
  wire hit_tap = reg_addr == OFS_WAKE_TAP;
  wire hit_legacy = reg_addr == OFS_LEGACY_DUTY;
  wire hit_coarse = reg_addr == OFS_COARSE_TRIM;
  wire hit_fine = reg_addr == OFS_FINE_TRIM;
  wire hit_status = reg_addr == OFS_SEQ_STATUS;

  wire [1:0] alt_buzz_select = buzz_i2c_q[ALT_BUZZ_LSB +: 2];
  wire i2c_sleep_on = buzz_i2c_q[I2C_SLEEP_BIT];
  wire slow_osc_sleep_disable = buzz_i2c_q[SLOW_OSC_OFF_BIT];
  wire wake_delay_double = wake_tap_q[DOUBLE_BIT];

  seq_state_t state_q, state_d;
  logic buzz_seq_q, buzz_seq_d;

  // reserved bits are dropped on write and read back as zero
  wire [DATA_W-1:0] rd_word =
    hit_buzz ? {4'h0, buzz_i2c_q} :
    hit_tap ? {1'b0, wake_tap_q} :
    hit_legacy ? {legacy_duty_q, 6'h00} :
    hit_coarse ? coarse_trim_q :
    hit_status ? {3'h0, buzz_seq_q, state_q} :
    8'h00; // fine trim is write-only; unmapped reads zero

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      buzz_i2c_q <= RST_BUZZ_I2C;
      wake_tap_q <= RST_WAKE_TAP;
      legacy_duty_q <= RST_LEGACY_DUTY;
      coarse_trim_q <= RST_COARSE_TRIM;
    end else if (reg_wr) begin
      if (hit_buzz) buzz_i2c_q <= reg_wdata[BUZZ_CFG_W-1:0];
      if (hit_tap) wake_tap_q <= reg_wdata[TAP_CFG_W-1:0];
      if (hit_legacy) legacy_duty_q <= reg_wdata[LEGACY_DUTY_LSB +: 2];
      if (hit_coarse) coarse_trim_q <= reg_wdata;
    end
  end

  // locking function wins over a software write in the same cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fine_trim_q <= RST_FINE_TRIM;
    end else if (lock_trim_wr) begin
      fine_trim_q <= lock_trim_val;
    end else if (reg_wr && hit_fine) begin
      fine_trim_q <= reg_wdata[FINE_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_word : 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // sleep controls and trim word
  // reserved alt code 11 keeps the legacy selection rather than an undefined rate
  wire [15:0] ratio_d =
    (alt_buzz_select == ALT_1_32768) ? RATIO_ALT_32768 :
    (alt_buzz_select == ALT_1_8192) ? RATIO_ALT_8192 :
    LEGACY_RATIO[legacy_duty_q];
  wire standby_d = sleep_active && i2c_sleep_on;
  wire slow_run_d = !(sleep_active && slow_osc_sleep_disable);
  wire [10:0] trim_d = {coarse_trim_q, fine_trim_q};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      buzz_on_ratio <= LEGACY_RATIO[RST_LEGACY_DUTY];
      i2c_standby_en <= 1'b0;
      slow_osc_run <= 1'b1;
      osc_trim_word <= {RST_COARSE_TRIM, RST_FINE_TRIM};
    end else begin
      buzz_on_ratio <= ratio_d;
      i2c_standby_en <= standby_d;
      slow_osc_run <= slow_run_d;
      osc_trim_word <= trim_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wakeup / buzz sequencer
  logic tmr_start;
  logic [DELAY_W-1:0] tmr_delay;
  logic tmr_expired;
  logic done_d;

  wake_phase_timer #(
    .US_CYC(US_CYC),
    .DLY_W(DELAY_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(tmr_start),
    .delay_us(tmr_delay),
    .expired(tmr_expired),
    .busy()
  );

  // taps are read live at each phase start; a change mid-sequence hits later phases
  always_comb begin
    state_d = state_q;
    buzz_seq_d = buzz_seq_q;
    tmr_start = 1'b0;
    tmr_delay = '0;
    done_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (wake_start || buzz_start) begin
          state_d = ST_FIRST;
          buzz_seq_d = !wake_start;
          tmr_start = 1'b1;
          tmr_delay = phase_delay(2'h0, wake_tap_q);
        end
      end
      ST_FIRST: begin
        if (tmr_expired) begin
          state_d = ST_SECOND;
          tmr_start = 1'b1;
          tmr_delay = phase_delay(2'h1, wake_tap_q);
        end
      end
      ST_SECOND: begin
        if (tmr_expired && buzz_seq_q) begin
          state_d = ST_IDLE;
          done_d = 1'b1;
        end else if (tmr_expired) begin
          state_d = ST_THIRD;
          tmr_start = 1'b1;
          tmr_delay = phase_delay(2'h2, wake_tap_q);
        end
      end
      ST_THIRD: begin
        if (tmr_expired) begin
          state_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      buzz_seq_q <= 1'b0;
      seq_done <= 1'b0;
    end else begin
      state_q <= state_d;
      buzz_seq_q <= buzz_seq_d;
      seq_done <= done_d;
    end
  end

  assign wake_phase = state_q[3:1];
  assign seq_busy = !state_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_standby_in_sleep: assert property (
    (sleep_active && i2c_sleep_on) |=> i2c_standby_en)
    else $error("standby regulator not enabled in i2c sleep");

  a_slow_osc_stop: assert property (
    (sleep_active && slow_osc_sleep_disable) |=> !slow_osc_run)
    else $error("slow oscillator still running in sleep");

  a_buzz_alt_rate: assert property (
    (alt_buzz_select == 2'h1) |=> (buzz_on_ratio == 16'h8000))
    else $error("alternate buzz code 01 ratio wrong");

  a_buzz_legacy_rate: assert property (
    (alt_buzz_select == 2'h0 && legacy_duty_q == 2'h3) |=> (buzz_on_ratio == 16'h0010))
    else $error("legacy buzz ratio not used in compatibility mode");

  // a software fine-trim write in the lock cycle must lose, so reg_wr is left free here
  a_trim_lock_join: assert property (
    lock_trim_wr |=> ##1
      (osc_trim_word == {$past(coarse_trim_q), $past(lock_trim_val, 2)}))
    else $error("locked fine trim not in trim word low bits");

  a_first_tap_delay: assert property (
    (state_q == ST_IDLE && wake_start && !wake_delay_double && wake_tap_q[1:0] == 2'h3)
      |-> (tmr_start && tmr_delay == 6'h1e))
    else $error("first phase delay wrong");

  a_double_delay: assert property (
    (state_q == ST_FIRST && tmr_expired && wake_delay_double && wake_tap_q[3:2] == 2'h3)
      |-> (tmr_delay == 6'h14))
    else $error("doubled second phase delay wrong");

  a_third_tap_delay: assert property (
    (state_q == ST_SECOND && tmr_expired && !buzz_seq_q && !wake_delay_double
      && wake_tap_q[5:4] == 2'h0) |-> (tmr_delay == 6'h01))
    else $error("third phase delay wrong");

  a_second_tap_delay: assert property (
    (state_q == ST_FIRST && tmr_expired && !wake_delay_double && wake_tap_q[3:2] == 2'h2)
      |-> (tmr_delay == 6'h05))
    else $error("second phase delay wrong");

  a_phase_order: assert property (
    (state_q == ST_FIRST && tmr_expired) |=> (wake_phase == 3'b010) ##0 $stable(buzz_seq_q))
    else $error("second phase did not follow first");

  a_buzz_skip_third: assert property (
    (state_q == ST_SECOND && tmr_expired && buzz_seq_q) |=> (!seq_busy && seq_done))
    else $error("buzz sequence entered third phase");

  a_reserved_read_zero: assert property (
    (reg_rd && hit_buzz) |=> (reg_rdata[7:4] == 4'h0))
    else $error("reserved bits read nonzero");

  c_wake_done: cover property ((state_q == ST_THIRD && tmr_expired) ##1 seq_done);
  c_buzz_done: cover property ((state_q == ST_SECOND && buzz_seq_q && tmr_expired) ##1 seq_done);
  c_double_wake: cover property (state_q == ST_IDLE && wake_start && wake_delay_double);
  c_lock_update: cover property (lock_trim_wr && reg_wr && hit_fine);

endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import sleep_wakeup_pkg::*;

  // short microsecond keeps every phase count small
  localparam int US = 2;
  localparam int FIRST_T [4] = '{10, 14, 20, 30};
  localparam int SECOND_T [4] = '{3, 4, 5, 10};
  localparam int THIRD_T [4] = '{1, 2, 5, 10};
  localparam logic [15:0] LEG_T [4] = '{16'h0100, 16'h0400, 16'h0040, 16'h0010};

  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sleep_active = 1'b0;
  logic wake_start = 1'b0;
  logic buzz_start = 1'b0;
  logic lock_trim_wr = 1'b0;
  logic [2:0] lock_trim_val = 3'h0;
  logic i2c_standby_en;
  logic slow_osc_run;
  logic [15:0] buzz_on_ratio;
  logic [10:0] osc_trim_word;
  logic [2:0] wake_phase;
  logic seq_busy;
  logic seq_done;
  int bad_count = 0;
  int samples_checked = 0;

  always #12.5 sys_clk = ~sys_clk;

  sleep_wakeup_config #(.US_CYC(US)) i_sleep_wakeup_config (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_active(sleep_active),
    .wake_start(wake_start), .buzz_start(buzz_start), .lock_trim_wr(lock_trim_wr),
    .lock_trim_val(lock_trim_val), .i2c_standby_en(i2c_standby_en), .slow_osc_run(slow_osc_run),
    .buzz_on_ratio(buzz_on_ratio), .osc_trim_word(osc_trim_word), .wake_phase(wake_phase),
    .seq_busy(seq_busy), .seq_done(seq_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, reg_rdata});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic run_seq(input logic [7:0] cfg, input bit wake);
    int n [3];
    int m;
    int k;
    n = '{0, 0, 0};
    m = cfg[6] ? 2 * US : US;
    wr(OFS_WAKE_TAP, cfg);
    @(posedge sys_clk);
    if (wake) wake_start <= 1'b1;
    else buzz_start <= 1'b1;
    @(posedge sys_clk);
    wake_start <= 1'b0;
    buzz_start <= 1'b0;
    #1;
    chk("busy_start", 16'h0001, {15'h0, seq_busy});
    for (k = 0; k < 3000; k++) begin
      #1;
      if (seq_done === 1'b1) break;
      if (wake_phase === 3'b001) n[0]++;
      else if (wake_phase === 3'b010) n[1]++;
      else if (wake_phase === 3'b100) n[2]++;
      @(posedge sys_clk);
    end
    chk("first_phase", 16'(FIRST_T[cfg[1:0]] * m), 16'(n[0]));
    chk("second_phase", 16'(SECOND_T[cfg[3:2]] * m), 16'(n[1]));
    chk("third_phase", wake ? 16'(THIRD_T[cfg[5:4]] * m) : 16'h0000, 16'(n[2]));
    chk("phase_at_done", 16'h0000, {13'h0, wake_phase});
    chk("seq_done", 16'h0001, {15'h0, seq_done});
    chk("busy_at_done", 16'h0000, {15'h0, seq_busy});
    settle(1);
    chk("done_pulse", 16'h0000, {15'h0, seq_done});
  endtask

  task automatic finish_test;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // sequences dominate the run time, a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end

  initial begin
    int a;
    int l;
    int i;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    settle(1);
    chk("slow_osc_reset", 16'h0001, {15'h0, slow_osc_run});
    chk("ratio_reset", 16'h0100, buzz_on_ratio);
    rd_chk("buzz_cfg_reset", OFS_BUZZ_I2C, 8'h00);
    rd_chk("tap_cfg_reset", OFS_WAKE_TAP, 8'h7f);
    rd_chk("unmapped", 8'h00, 8'h00);
    rd_chk("status_idle", OFS_SEQ_STATUS, 8'h01);
    // read data stand for one cycle only
    settle(1);
    chk("rdata_idle", 16'h0000, {8'h00, reg_rdata});
    // software keeps reserved positions at zero; they read back as zero
    wr(OFS_BUZZ_I2C, 8'h0c);
    rd_chk("buzz_cfg_rsvd", OFS_BUZZ_I2C, 8'h0c);
    wr(OFS_WAKE_TAP, 8'h7f);
    rd_chk("tap_cfg_rsvd", OFS_WAKE_TAP, 8'h7f);
    // every alternate code against every legacy code
    for (a = 0; a < 4; a++) begin
      for (l = 0; l < 4; l++) begin
        wr(OFS_LEGACY_DUTY, 8'(l << 6));
        wr(OFS_BUZZ_I2C, 8'(a << 2));
        settle(2);
        chk("buzz_ratio", (a == 1) ? 16'h8000 : (a == 2) ? 16'h2000 : LEG_T[l], buzz_on_ratio);
      end
    end
    wr(OFS_BUZZ_I2C, 8'h03);
    settle(2);
    chk("standby_awake", 16'h0000, {15'h0, i2c_standby_en});
    @(posedge sys_clk);
    sleep_active <= 1'b1;
    settle(2);
    chk("standby_asleep", 16'h0001, {15'h0, i2c_standby_en});
    chk("slow_osc_asleep", 16'h0000, {15'h0, slow_osc_run});
    @(posedge sys_clk);
    sleep_active <= 1'b0;
    settle(2);
    chk("slow_osc_awake", 16'h0001, {15'h0, slow_osc_run});
    wr(OFS_BUZZ_I2C, 8'h00);
    @(posedge sys_clk);
    sleep_active <= 1'b1;
    settle(2);
    chk("slow_osc_kept", 16'h0001, {15'h0, slow_osc_run});
    @(posedge sys_clk);
    sleep_active <= 1'b0;
    wr(OFS_COARSE_TRIM, 8'ha5);
    wr(OFS_FINE_TRIM, 8'h06);
    settle(2);
    chk("trim_word", {5'h00, 11'h52e}, {5'h00, osc_trim_word});
    rd_chk("fine_write_only", OFS_FINE_TRIM, 8'h00);
    // a software fine-trim write in the same cycle must lose to the locking function
    @(posedge sys_clk);
    lock_trim_wr <= 1'b1;
    lock_trim_val <= 3'h3;
    reg_addr <= OFS_FINE_TRIM;
    reg_wdata <= 8'h05;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    lock_trim_wr <= 1'b0;
    reg_wr <= 1'b0;
    settle(2);
    chk("trim_locked", {5'h00, 11'h52b}, {5'h00, osc_trim_word});
    // same code in all three tap fields plain; doubled runs put code 3-i in the third field
    for (i = 0; i < 4; i++) begin
      run_seq(8'(i | (i << 2) | (i << 4)), 1'b1);
      run_seq(8'(8'h40 | i | (i << 2) | (3 - i) << 4), 1'b1);
    end
    run_seq(8'h3e, 1'b0);
    run_seq(8'h7f, 1'b0);
    finish_test();
  end
endmodule
